// File: spi_eeprom_pkg.sv
// Shared constants, carrier types and error-correction helpers for the
// serial EEPROM slave, plus the small two-entry byte buffer it uses.
// Assumes one system clock; all serial pins are sampled on that clock.
`timescale 1ns/1ps
package spi_eeprom_pkg;
  localparam int          PAGE_COUNT   = 256;
  localparam int          PAGE_BYTES   = 64;
  localparam int          MAIN_DEPTH   = PAGE_COUNT * PAGE_BYTES;
  localparam int          ADDR_W       = 14;
  localparam int          PAGE_W       = 6;
  localparam int          LOCK_HI_BIT  = 2;
  localparam logic [7:0]  OP_WRSR      = 8'h01;
  localparam logic [7:0]  OP_WRITE     = 8'h02;
  localparam logic [7:0]  OP_READ      = 8'h03;
  localparam logic [7:0]  OP_WRDI      = 8'h04;
  localparam logic [7:0]  OP_RDSR      = 8'h05;
  localparam logic [7:0]  OP_WREN      = 8'h06;
  localparam logic [7:0]  OP_WRID      = 8'h82;
  localparam logic [7:0]  OP_RDID      = 8'h83;
  localparam logic [1:0]  BP_RESET     = 2'h0;
  localparam logic        SRWD_RESET   = 1'b0;
  localparam logic [3:0]  ECC_COL [8]  = '{4'h3, 4'h5, 4'h6, 4'h7,
                                           4'h9, 4'ha, 4'hb, 4'hc};

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } pins_t;

  typedef struct packed {
    logic [3:0] check;
    logic [7:0] data;
  } codeword_t;

  function automatic logic [3:0] ecc_check(input logic [7:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int j = 0; j < 8; j++) begin
      if (d[j]) c = c ^ ECC_COL[j];
    end
    return c;
  endfunction

  function automatic codeword_t ecc_encode(input logic [7:0] d);
    codeword_t w;
    w.data  = d;
    w.check = ecc_check(d);
    return w;
  endfunction

  // Corrects any single flipped data bit; check-bit hits need no repair
  function automatic logic [7:0] ecc_fix(input codeword_t w);
    logic [3:0] syn;
    logic [7:0] d;
    d   = w.data;
    syn = w.check ^ ecc_check(w.data);
    for (int j = 0; j < 8; j++) begin
      if (syn == ECC_COL[j]) d[j] = ~d[j];
    end
    return d;
  endfunction
endpackage

module byte_buffer2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wptr;
  logic [PW-1:0]    next_rptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (PW+1)'(DEPTH)) && !flush;
  assign out_valid = (count != '0) && !flush;
  assign out_data  = slot[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wptr  = push ? PW'(wptr + 1'b1) : wptr;
    next_rptr  = pop ? PW'(rptr + 1'b1) : rptr;
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    if (flush) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) slot[wptr] <= in_data;
  end
endmodule

// File: spi_eeprom_port.sv
// Serial slave port of a byte-alterable EEPROM with an ID page.
// Assumes mclk runs far faster than the serial clock: every pin is
// resynchronised and serial clock edges are found by sampling.
`timescale 1ns/1ps
module spi_eeprom_port (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      so_out,
  output logic      so_oe
);
  import spi_eeprom_pkg::*;

  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_RD    = 3'b010,
    ST_WR    = 3'b011,
    ST_SR_RD = 3'b100,
    ST_SR_WR = 3'b101,
    ST_DONE  = 3'b110
  } state_t;

  pins_t            pin_a;
  pins_t            pin_s;
  logic             sclk_q;
  state_t           state;
  state_t           next_state;
  logic             armed;
  logic             next_armed;
  logic             paused;
  logic             next_paused;
  logic [2:0]       bit_cnt;
  logic [2:0]       next_bit_cnt;
  logic [7:0]       in_sh;
  logic [7:0]       next_in_sh;
  logic [7:0]       opcode;
  logic [7:0]       next_opcode;
  logic             addr_cnt;
  logic             next_addr_cnt;
  logic [7:0]       addr_hi;
  logic [7:0]       next_addr_hi;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0]       out_sh;
  logic [7:0]       next_out_sh;
  logic [2:0]       out_cnt;
  logic [2:0]       next_out_cnt;
  logic             so_bit;
  logic             next_so_bit;
  logic             so_active;
  logic             next_so_active;
  logic             wel;
  logic             next_wel;
  logic             wrote;
  logic             next_wrote;
  logic             srwd;
  logic             next_srwd;
  logic [1:0]       bp;
  logic [1:0]       next_bp;
  logic             locked;
  logic             next_locked;
  codeword_t        main_mem [MAIN_DEPTH];
  codeword_t        id_mem [PAGE_BYTES];
  logic             sel;
  logic             rise;
  logic             fall;
  logic             live;
  logic             reading;
  logic             is_id;
  logic             lock_cmd;
  logic             prot;
  logic             wr_main;
  logic             wr_id;
  logic [7:0]       byte_in;
  logic [7:0]       status;
  logic             fill_valid;
  logic             fill_ready;
  logic [7:0]       fill_data;
  logic             drain_valid;
  logic             drain_ready;
  logic [7:0]       drain_data;

  // Two stages before any logic; sclk_q is the third, for edge finding
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a  <= '0;
      pin_s  <= '0;
      sclk_q <= 1'b0;
    end else begin
      pin_a  <= pins_t'{sclk, cs_n, si, hold_n, wp_n};
      pin_s  <= pin_a;
      sclk_q <= pin_s.sclk;
    end
  end

  // Either idle level works since only edges are used
  assign rise     = pin_s.sclk && !sclk_q;
  assign fall     = !pin_s.sclk && sclk_q;
  assign sel      = armed && !pin_s.cs_n;
  assign live     = sel && !paused;
  assign byte_in  = {in_sh[6:0], pin_s.si};
  assign reading  = state == ST_RD || state == ST_SR_RD;
  assign is_id    = opcode == OP_RDID || opcode == OP_WRID;
  assign lock_cmd = is_id && addr_hi[LOCK_HI_BIT];
  assign status   = {srwd, 3'h0, bp, wel, 1'b0};
  assign prot     = bp == 2'h3 || (bp == 2'h2 && addr[ADDR_W-1]) ||
                    (bp == 2'h1 && addr[ADDR_W-1:ADDR_W-2] == 2'h3);
  assign wr_main  = live && rise && bit_cnt == 3'h7 && state == ST_WR &&
                    wel && !is_id && !prot;
  assign wr_id    = live && rise && bit_cnt == 3'h7 && state == ST_WR &&
                    wel && is_id && !lock_cmd && !locked && bp != 2'h3;
  assign so_out   = so_bit;
  assign so_oe    = so_active && live && reading;

  // Prefetch into the buffer so a byte is ready at each byte boundary
  assign fill_valid  = sel && reading;
  assign fill_data   = state == ST_SR_RD ? status :
                       is_id ? ecc_fix(id_mem[addr[PAGE_W-1:0]]) :
                       ecc_fix(main_mem[addr]);
  assign drain_ready = live && fall && reading && out_cnt == 3'h0;

  byte_buffer2 #(.WIDTH(8), .DEPTH(2)) u_buf (
    .clk       (mclk),
    .rst_n     (rst_n),
    .flush     (!reading),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (fill_data),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  always_comb begin
    next_state     = state;
    next_armed     = armed || pin_s.cs_n;
    next_paused    = paused;
    next_bit_cnt   = bit_cnt;
    next_in_sh     = in_sh;
    next_opcode    = opcode;
    next_addr_cnt  = addr_cnt;
    next_addr_hi   = addr_hi;
    next_addr      = addr;
    next_out_sh    = out_sh;
    next_out_cnt   = out_cnt;
    next_so_bit    = so_bit;
    next_so_active = so_active;
    next_wel       = wel;
    next_wrote     = wrote;
    next_srwd      = srwd;
    next_bp        = bp;
    next_locked    = locked;
    if (!sel) begin
      next_state     = ST_CMD;
      next_paused    = 1'b0;
      next_bit_cnt   = 3'h0;
      next_out_cnt   = 3'h0;
      next_so_active = 1'b0;
      next_wrote     = 1'b0;
      if (wrote) next_wel = 1'b0;
    end else begin
      // Pause only begins or ends with the clock low
      if (!pin_s.sclk && !pin_s.hold_n) next_paused = 1'b1;
      if (!pin_s.sclk && pin_s.hold_n) next_paused = 1'b0;
      if (!paused && rise) begin
        next_in_sh   = byte_in;
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          unique case (state)
            ST_CMD: begin
              next_opcode   = byte_in;
              next_addr_cnt = 1'b0;
              next_state    = ST_DONE;
              if (byte_in == OP_WREN) next_wel = 1'b1;
              if (byte_in == OP_WRDI) next_wel = 1'b0;
              if (byte_in == OP_RDSR) next_state = ST_SR_RD;
              if (byte_in == OP_WRSR) next_state = ST_SR_WR;
              if (byte_in == OP_READ || byte_in == OP_WRITE ||
                  byte_in == OP_RDID || byte_in == OP_WRID)
                next_state = ST_ADDR;
            end
            ST_ADDR: begin
              next_addr_cnt = 1'b1;
              next_addr_hi  = addr_cnt ? addr_hi : byte_in;
              if (addr_cnt) begin
                next_addr  = {addr_hi[ADDR_W-9:0], byte_in};
                next_state = (opcode == OP_READ || opcode == OP_RDID) ?
                             ST_RD : ST_WR;
              end
            end
            ST_WR: begin
              // Writes roll over inside the current page
              next_addr  = {addr[ADDR_W-1:PAGE_W],
                            PAGE_W'(addr[PAGE_W-1:0] + 1'b1)};
              next_wrote = wel;
              if (wel && lock_cmd && bp != 2'h3) next_locked = 1'b1;
            end
            ST_SR_WR: begin
              next_state = ST_DONE;
              next_wrote = wel;
              if (wel && !(srwd && !pin_s.wp_n)) begin
                next_srwd = byte_in[7];
                next_bp   = byte_in[3:2];
              end
            end
            ST_RD, ST_SR_RD, ST_DONE: begin
            end
            default: next_state = ST_DONE;
          endcase
        end
      end
      if (!paused && fall && reading) begin
        next_so_active = 1'b1;
        next_out_cnt   = out_cnt - 3'h1;
        if (out_cnt == 3'h0) begin
          next_so_bit = drain_valid && drain_data[7];
          next_out_sh = {drain_data[6:0], 1'b0};
        end else begin
          next_so_bit = out_sh[7];
          next_out_sh = {out_sh[6:0], 1'b0};
        end
      end
      if (state == ST_RD && fill_ready) begin
        next_addr = is_id ? {addr[ADDR_W-1:PAGE_W],
                             PAGE_W'(addr[PAGE_W-1:0] + 1'b1)} :
                            ADDR_W'(addr + 1'b1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_CMD;
      armed     <= 1'b0;
      paused    <= 1'b0;
      bit_cnt   <= 3'h0;
      in_sh     <= 8'h00;
      opcode    <= 8'h00;
      addr_cnt  <= 1'b0;
      addr_hi   <= 8'h00;
      addr      <= '0;
      out_sh    <= 8'h00;
      out_cnt   <= 3'h0;
      so_bit    <= 1'b0;
      so_active <= 1'b0;
      wel       <= 1'b0;
      wrote     <= 1'b0;
      srwd      <= SRWD_RESET;
      bp        <= BP_RESET;
      locked    <= 1'b0;
    end else begin
      state     <= next_state;
      armed     <= next_armed;
      paused    <= next_paused;
      bit_cnt   <= next_bit_cnt;
      in_sh     <= next_in_sh;
      opcode    <= next_opcode;
      addr_cnt  <= next_addr_cnt;
      addr_hi   <= next_addr_hi;
      addr      <= next_addr;
      out_sh    <= next_out_sh;
      out_cnt   <= next_out_cnt;
      so_bit    <= next_so_bit;
      so_active <= next_so_active;
      wel       <= next_wel;
      wrote     <= next_wrote;
      srwd      <= next_srwd;
      bp        <= next_bp;
      locked    <= next_locked;
    end
  end

  // Arrays hold no reset: contents are the memory itself
  always_ff @(posedge mclk) begin
    if (wr_main) main_mem[addr] <= ecc_encode(byte_in);
    if (wr_id) id_mem[addr[PAGE_W-1:0]] <= ecc_encode(byte_in);
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_float_idle: assert property (!(sel && reading)
    |-> !so_oe ##1 !so_active)
    else $error("Output enabled outside a read");
  a_desel_release: assert property ($rose(pin_s.cs_n)
    |-> !so_oe ##1 !so_active)
    else $error("Output still driven after deselect");
  a_pause_float: assert property (paused |-> !so_oe)
    else $error("Output driven while paused");
  a_out_on_fall: assert property ($changed(so_bit) |-> $past(fall))
    else $error("Output bit moved without a falling edge");
  a_msb_first: assert property (drain_ready && drain_valid
    |=> so_bit == $past(drain_data[7]))
    else $error("Byte did not start with its msb");
  a_in_on_rise: assert property ($changed(bit_cnt) && $past(sel)
    |-> $past(rise) && !$past(paused))
    else $error("Bit counted without a rising edge");
  a_pause_freeze: assert property (paused && sel
    |=> $stable(bit_cnt) && $stable(state))
    else $error("Transfer state moved while paused");
  a_first_fall: assert property ($rose(armed) |-> $past(pin_s.cs_n))
    else $error("Armed without select seen high");
  a_desel_clear: assert property (!sel ##1 !sel
    |-> bit_cnt == 3'h0 && state == ST_CMD && !paused)
    else $error("Serial state not cleared while deselected");
  a_status_guard: assert property (srwd && !pin_s.wp_n && $stable(pin_s.wp_n)
    |=> $stable(bp) && $stable(srwd))
    else $error("Protected status changed");
endmodule

// File: spi_master_model.sv
// Bus master model for the serial EEPROM port: clock, select, data, pause.
// Assumes the bench's mclk; every pin it drives changes on mclk falls.
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic mclk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  output logic      wp_n
);
  // Unequal halves give the 125 ns link period at 5 ns per mclk
  localparam int HALF_LO = 12;
  localparam int HALF_HI = 13;
  logic          cpol;

  initial begin
    sclk   = 1'b0;
    cs_n   = 1'b1;
    si     = 1'b0;
    hold_n = 1'b1;
    wp_n   = 1'b1;
    cpol   = 1'b0;
  end

  task automatic wait_mclk(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Select falls with the clock parked at the mode's idle level
  task automatic open_frame(input logic mode_hi);
    cpol = mode_hi;
    sclk = mode_hi;
    wait_mclk(HALF_LO);
    cs_n = 1'b0;
    wait_mclk(HALF_LO);
  endtask

  // Bit set while the clock is low, reply taken at the rising edge
  task automatic shift(input logic [7:0] tx, input int n,
                       output logic [7:0] rx, output logic [7:0] oe);
    rx = 8'h00;
    oe = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      si   = tx[i];
      wait_mclk(HALF_LO);
      sclk  = 1'b1;
      rx[i] = so;
      oe[i] = so_oe;
      wait_mclk(HALF_HI);
    end
  endtask

  // A pause may only start with the clock low
  task automatic park();
    sclk = 1'b0;
    wait_mclk(HALF_LO);
    hold_n = 1'b0;
  endtask

  // Pause released while the clock is still parked low
  task automatic resume();
    hold_n = 1'b1;
  endtask

  // Clock edges while paused, with a changing data line
  task automatic junk(input int n);
    repeat (n) begin
      sclk = 1'b1;
      si   = ~si;
      wait_mclk(HALF_HI);
      sclk = 1'b0;
      wait_mclk(HALF_LO);
    end
  endtask

  // Released data line shows the inverse so a stale value cannot pass
  task automatic close_frame();
    sclk = cpol;
    wait_mclk(HALF_LO);
    cs_n = 1'b1;
    si   = ~si;
    wait_mclk(2 * HALF_HI);
  endtask
endmodule

// File: test_spi_eeprom_serial_port.sv
// Self-checking bench for the serial EEPROM port, frames as table rows.
// Assumes the design package and the master model are compiled first.
`timescale 1ns/1ps
module test_spi_eeprom_serial_port;
  import spi_eeprom_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] addr;
    logic [7:0]  dat;
    logic [1:0]  flags;
  } row_t;
  localparam int NROWS = 29;
  // About 21k cycles of frames; the ceiling leaves room to spare
  localparam int LIMIT = 60000;
  logic          mclk;
  logic          rst_n;
  logic          sclk;
  logic          cs_n;
  logic          si;
  logic          hold_n;
  logic          wp_n;
  logic          so_out;
  logic          so_oe;
  logic          so;
  logic [7:0]    rx;
  logic [7:0]    oe;
  logic [7:0]    got;
  logic          idle_hi;
  int            bad_count;
  int            checked;
  int            cycles;
  int            hi_cnt;
  // Flags are {wp_n, idle-high clock}; dat is sent or expected back
  row_t rows [NROWS] = '{
    '{8'h06, 16'h0000, 8'h00, 2'h2}, '{8'h02, 16'h0123, 8'ha5, 2'h2},
    '{8'h03, 16'h0123, 8'ha5, 2'h2}, '{8'h05, 16'h0000, 8'h00, 2'h2},
    '{8'h06, 16'h0000, 8'h00, 2'h2}, '{8'h02, 16'h3fff, 8'h3c, 2'h2},
    '{8'h03, 16'h3fff, 8'h3c, 2'h3}, '{8'h02, 16'h0123, 8'h11, 2'h2},
    '{8'h03, 16'h0123, 8'ha5, 2'h3}, '{8'h06, 16'h0000, 8'h00, 2'h2},
    '{8'h04, 16'h0000, 8'h00, 2'h2}, '{8'h05, 16'h0000, 8'h00, 2'h2},
    '{8'h06, 16'h0000, 8'h00, 2'h2}, '{8'h82, 16'h0005, 8'h77, 2'h2},
    '{8'h83, 16'h0005, 8'h77, 2'h3}, '{8'h06, 16'h0000, 8'h00, 2'h2},
    '{8'h82, 16'h0400, 8'h00, 2'h2}, '{8'h06, 16'h0000, 8'h00, 2'h2},
    '{8'h82, 16'h0005, 8'h55, 2'h2}, '{8'h83, 16'h0005, 8'h77, 2'h2},
    '{8'h06, 16'h0000, 8'h00, 2'h2}, '{8'h01, 16'h0000, 8'h80, 2'h2},
    '{8'h05, 16'h0000, 8'h80, 2'h2}, '{8'h06, 16'h0000, 8'h00, 2'h0},
    '{8'h01, 16'h0000, 8'h00, 2'h0}, '{8'h05, 16'h0000, 8'h80, 2'h0},
    '{8'h06, 16'h0000, 8'h00, 2'h2}, '{8'h01, 16'h0000, 8'h00, 2'h2},
    '{8'h05, 16'h0000, 8'h00, 2'h2}};

  assign so = so_oe ? so_out : 1'bz;

  spi_eeprom_port uut (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .sclk   (sclk),
    .cs_n   (cs_n),
    .si     (si),
    .hold_n (hold_n),
    .wp_n   (wp_n),
    .so_out (so_out),
    .so_oe  (so_oe)
  );

  spi_master_model master (
    .mclk   (mclk),
    .so     (so),
    .so_oe  (so_oe),
    .sclk   (sclk),
    .cs_n   (cs_n),
    .si     (si),
    .hold_n (hold_n),
    .wp_n   (wp_n)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Output must be floating a few mclk after every deselect
  always @(negedge mclk) begin
    hi_cnt = cs_n ? hi_cnt + 1 : 0;
    if (hi_cnt == 5) check({7'h00, so_oe}, 8'h00);
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      conclude();
    end
  end

  task automatic run_row(input row_t r);
    logic rd;
    rd = r.op inside {OP_READ, OP_RDSR, OP_RDID};
    master.wp_n = r.flags[1];
    master.open_frame(r.flags[0]);
    master.shift(r.op, 8, rx, oe);
    check(oe, 8'h00);
    if (r.op inside {OP_WRITE, OP_READ, OP_WRID, OP_RDID}) begin
      master.shift(r.addr[15:8], 8, rx, oe);
      master.shift(r.addr[7:0], 8, rx, oe);
      check(oe, 8'h00);
    end
    if (r.op != OP_WREN && r.op != OP_WRDI) begin
      master.shift(rd ? 8'h00 : r.dat, 8, rx, oe);
      check(oe, rd ? 8'hff : 8'h00);
      if (rd) check(rx, r.dat);
    end
    master.close_frame();
  endtask

  initial begin
    rst_n     = 1'b0;
    bad_count = 0;
    checked   = 0;
    cycles    = 0;
    hi_cnt    = 0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    master.wait_mclk(8);
    for (int k = 0; k < NROWS; k++) run_row(rows[k]);
    // Pause mid-byte on an idle-high clock, junk edges, finish the byte
    idle_hi = 1'b1;
    master.open_frame(idle_hi);
    master.shift(OP_READ, 8, rx, oe);
    master.shift(8'h01, 8, rx, oe);
    master.shift(8'h23, 8, rx, oe);
    master.shift(8'h00, 4, rx, oe);
    got = rx;
    master.park();
    master.wait_mclk(8);
    check({7'h00, so_oe}, 8'h00);
    master.junk(3);
    master.resume();
    master.wait_mclk(8);
    master.shift(8'h00, 4, rx, oe);
    check({got[7:4], rx[7:4]}, 8'ha5);
    master.close_frame();
    // Deselect while paused must drop the half-sent address
    idle_hi = ~idle_hi;
    master.open_frame(idle_hi);
    master.shift(OP_READ, 8, rx, oe);
    master.shift(8'h3f, 4, rx, oe);
    master.park();
    master.wait_mclk(8);
    master.close_frame();
    master.resume();
    run_row('{8'h03, 16'h3fff, 8'h3c, 2'h2});
    // A data byte cut short by deselect is not written
    run_row('{8'h06, 16'h0000, 8'h00, 2'h2});
    idle_hi = ~idle_hi;
    master.open_frame(idle_hi);
    master.shift(OP_WRITE, 8, rx, oe);
    master.shift(8'h01, 8, rx, oe);
    master.shift(8'h23, 8, rx, oe);
    master.shift(8'h11, 4, rx, oe);
    master.close_frame();
    run_row('{8'h03, 16'h0123, 8'ha5, 2'h2});
    // Reset with select already low: no answer until select rises
    idle_hi = ~idle_hi;
    master.open_frame(idle_hi);
    rst_n = 1'b0;
    master.wait_mclk(4);
    rst_n = 1'b1;
    master.wait_mclk(8);
    master.shift(OP_RDSR, 8, rx, oe);
    master.shift(8'h00, 8, rx, oe);
    check(oe, 8'h00);
    master.close_frame();
    run_row('{8'h05, 16'h0000, 8'h00, 2'h2});
    conclude();
  end
endmodule
